// ### rtl/line_memory.sv
// serial-access 2048x8 video line memory with five scan modes and apb control
// assumes video clocks are one-cycle enables on core_clk; all pins synchronous except resetn (async reset) and output_gate_n (drives data_out_oe directly)
`timescale 1ns/1ps
module line_memory (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  // apb slave
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // video side
  input  wire logic                  read_clk_en,
  input  wire logic                  write_clk_en,
  input  wire logic                  read_pointer_clear_n,
  input  wire logic                  write_pointer_clear_n,
  input  wire logic                  write_gate_n,
  input  wire logic                  write_timing_strobe,
  input  wire logic                  output_gate_n,
  input  wire logic [7:0]            data_in,
  output logic [7:0]                 data_out,
  output logic                       data_out_oe,
  output line_memory_pkg::decode_type decode_out
);

  // ---------------- control register ----------------
  logic [31:0]              ctrl_reg;        // software mode word
  logic [31:0]              ctrl_next;
  line_memory_pkg::ctrl_type ctrl_fields;    // low bits as fields
  line_memory_pkg::mode_type mode;           // decoded mode

  // ---------------- counters and flags ----------------
  logic [10:0] rd_cnt_reg;     // read (or common) counter
  logic [10:0] rd_cnt_next;
  logic [10:0] wr_cnt_reg;     // write counter, two-clock modes
  logic [10:0] wr_cnt_next;
  logic        rd_armed_reg;   // read clear may fire
  logic        rd_armed_next;
  logic        wr_armed_reg;   // write clear may fire
  logic        wr_armed_next;
  logic        inhibit_reg;    // automatic write stop
  logic        inhibit_next;
  logic        phase_reg;      // dual delay half-cycle phase
  logic        phase_next;
  logic        wr_bank_reg;    // double rate write bank
  logic        wr_bank_next;
  logic [7:0]  carry_reg;      // one-line sample moving into second line
  logic [7:0]  carry_next;
  logic [7:0]  dout_reg;       // registered data output
  logic [7:0]  dout_next;
  logic [5:0]  dec_reg;        // active-low decode latch
  logic [5:0]  dec_next;

  // ---------------- storage ----------------
  logic [7:0]  mem_reg [line_memory_pkg::DEPTH];

  // ---------------- derived strobes ----------------
  logic        single_clock;   // one clock drives both sides
  logic        wr_en;          // write-side clock pulse
  logic        wr_clear_n;     // clear seen by write side
  logic        rd_clear_ev;    // read clear takes effect now
  logic        wr_clear_ev;    // write clear takes effect now
  logic        mem_we;         // storage write this cycle
  logic [10:0] mem_waddr;
  logic [7:0]  mem_wdata;
  logic [10:0] mem_raddr;
  logic [7:0]  mem_rdata;
  logic        wr_at_limit;    // write counter on its last location

  assign ctrl_fields = line_memory_pkg::ctrl_type'(ctrl_reg[3:0]);

  // mode decode from the three select bits
  always_comb begin
    case ({ctrl_fields.mode_select_a, ctrl_fields.mode_select_b})
      2'b11:   mode = ctrl_fields.mode_select_c ? line_memory_pkg::compression_expansion_mode
                                                : line_memory_pkg::double_rate_mode;
      2'b10:   mode = line_memory_pkg::timebase_correct_mode;
      2'b01:   mode = line_memory_pkg::dual_line_delay_mode;
      default: mode = line_memory_pkg::delay_line_mode;
    endcase
  end

  // delay modes run from one clock and one common clear
  assign single_clock = (mode == line_memory_pkg::dual_line_delay_mode) ||
                        (mode == line_memory_pkg::delay_line_mode);
  assign wr_en      = single_clock ? read_clk_en : write_clk_en;
  assign wr_clear_n = single_clock ? read_pointer_clear_n : write_pointer_clear_n;

  // a clear fires once per low period, on the first clock after it falls
  assign rd_clear_ev = read_clk_en & ~read_pointer_clear_n & rd_armed_reg;
  assign wr_clear_ev = wr_en & ~wr_clear_n & wr_armed_reg;

  // inhibit limit depends on mode; correction and delay line have none
  always_comb begin
    case (mode)
      line_memory_pkg::compression_expansion_mode:
        wr_at_limit = (wr_cnt_reg == line_memory_pkg::FULL_LAST);
      line_memory_pkg::double_rate_mode:
        wr_at_limit = (wr_cnt_reg[9:0] == line_memory_pkg::HALF_LAST[9:0]);
      line_memory_pkg::dual_line_delay_mode:
        wr_at_limit = (rd_cnt_reg[9:0] == line_memory_pkg::HALF_LAST[9:0]) & phase_reg;
      default:
        wr_at_limit = 1'b0;
    endcase
  end

  // ---------------- apb slave ----------------
  // zero wait states; unmapped addresses answer with slave error
  assign pready = 1'b1;

  always_comb begin
    ctrl_next = ctrl_reg;
    prdata    = 32'h0000_0000;
    pslverr   = 1'b0;
    if (psel) begin
      case (paddr)
        line_memory_pkg::CTRL_OFFSET: begin
          prdata = {28'h000_0000, ctrl_reg[3:0]};
          if (penable && pwrite) begin
            ctrl_next = {28'h000_0000, pwdata[3:0]};
          end
        end
        line_memory_pkg::STATUS_OFFSET: begin
          prdata = {4'h0, phase_reg, wr_bank_reg, inhibit_reg, wr_cnt_reg,
                    1'b0, rd_cnt_reg, 2'b00};
        end
        default: begin
          pslverr = penable;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= line_memory_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ---------------- counters ----------------
  // counters reset to 0 here, but contents mean nothing until a clear cycle
  always_comb begin
    rd_cnt_next   = rd_cnt_reg;
    wr_cnt_next   = wr_cnt_reg;
    rd_armed_next = rd_armed_reg;
    wr_armed_next = wr_armed_reg;
    inhibit_next  = inhibit_reg;
    phase_next    = phase_reg;
    wr_bank_next  = wr_bank_reg;
    // re-arm when the clear is seen high again
    if (read_pointer_clear_n) begin
      rd_armed_next = 1'b1;
    end else if (rd_clear_ev) begin
      rd_armed_next = 1'b0;
    end
    if (wr_clear_n) begin
      wr_armed_next = 1'b1;
    end else if (wr_clear_ev) begin
      wr_armed_next = 1'b0;
    end
    // read or common counter
    if (read_clk_en) begin
      if (rd_clear_ev) begin
        rd_cnt_next = 11'h000;
        phase_next  = 1'b0;
      end else if (mode == line_memory_pkg::dual_line_delay_mode) begin
        // two clocks per location: first half one-line, second two-line
        phase_next = ~phase_reg;
        if (phase_reg) begin
          rd_cnt_next = (rd_cnt_reg[9:0] == line_memory_pkg::HALF_LAST[9:0]) ?
                        rd_cnt_reg : rd_cnt_reg + 11'h001;
        end
      end else begin
        rd_cnt_next = rd_cnt_reg + 11'h001;
      end
    end
    // write counter, two-clock modes only
    if (!single_clock && write_clk_en) begin
      if (wr_clear_ev) begin
        wr_cnt_next = 11'h000;
        if (mode == line_memory_pkg::double_rate_mode) begin
          wr_bank_next = ~wr_bank_reg;
        end
      end else begin
        wr_cnt_next = wr_cnt_reg + 11'h001;
      end
    end
    // inhibit: set after the limit is passed, cleared by a write clear
    if (wr_clear_ev) begin
      inhibit_next = 1'b0;
    end else if (wr_en && wr_at_limit) begin
      inhibit_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_cnt_reg   <= 11'h000;
      wr_cnt_reg   <= 11'h000;
      rd_armed_reg <= 1'b1;
      wr_armed_reg <= 1'b1;
      inhibit_reg  <= 1'b0;
      phase_reg    <= 1'b0;
      wr_bank_reg  <= 1'b0;
    end else begin
      rd_cnt_reg   <= rd_cnt_next;
      wr_cnt_reg   <= wr_cnt_next;
      rd_armed_reg <= rd_armed_next;
      wr_armed_reg <= wr_armed_next;
      inhibit_reg  <= inhibit_next;
      phase_reg    <= phase_next;
      wr_bank_reg  <= wr_bank_next;
    end
  end

  // ---------------- storage addressing ----------------
  // delay modes read a location then overwrite it, so the delay equals the
  // clear period; with no clear the delay line counter wraps and the delay is 2048, while the dual delay counter holds at 1023
  always_comb begin
    mem_raddr = rd_cnt_reg;
    mem_waddr = wr_cnt_reg;
    mem_wdata = data_in;
    mem_we    = 1'b0;
    carry_next = carry_reg;
    case (mode)
      line_memory_pkg::compression_expansion_mode,
      line_memory_pkg::timebase_correct_mode: begin
        mem_we = write_clk_en & ~write_gate_n & ~inhibit_reg;
      end
      line_memory_pkg::double_rate_mode: begin
        mem_waddr = {wr_bank_reg, wr_cnt_reg[9:0]};
        mem_we    = write_clk_en & ~write_gate_n & ~inhibit_reg;
      end
      line_memory_pkg::dual_line_delay_mode: begin
        // bank 0 holds the one-line delay, bank 1 the two-line delay
        mem_raddr = phase_reg ? (rd_cnt_reg | line_memory_pkg::HALF_BASE)
                              : {1'b0, rd_cnt_reg[9:0]};
        mem_waddr = mem_raddr;
        mem_wdata = phase_reg ? carry_reg : data_in;
        mem_we    = read_clk_en & ~inhibit_reg &
                    (phase_reg | ~write_timing_strobe);
        if (read_clk_en && !phase_reg) begin
          carry_next = mem_rdata;
        end
      end
      line_memory_pkg::delay_line_mode: begin
        mem_waddr = rd_cnt_reg;
        mem_we    = read_clk_en & ~write_gate_n;
      end
      default: begin
        mem_we = 1'b0;
      end
    endcase
  end

  assign mem_rdata = mem_reg[mem_raddr];

  // storage is plain flip-flops; no reset so it maps to an array
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem_reg[mem_waddr] <= mem_wdata;
    end
  end

  // ---------------- data output ----------------
  // output is the word at the read location before the step; at pointer
  // coincidence the old word is shown, so the fresh write is not seen
  always_comb begin
    dout_next = dout_reg;
    if (read_clk_en) begin
      dout_next = mem_rdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dout_reg  <= 8'h00;
      carry_reg <= 8'h00;
    end else begin
      dout_reg  <= dout_next;
      carry_reg <= carry_next;
    end
  end

  assign data_out    = dout_reg;
  assign data_out_oe = ~output_gate_n;

  // ---------------- decode latch ----------------
  // each pulse is latched one location early and shown at the target, so a
  // clear taken at the target still leaves the pulse standing
  always_comb begin
    logic [10:0] rn;
    logic [10:0] wn;
    rn = rd_cnt_reg + 11'h001;
    wn = wr_cnt_reg + 11'h001;
    dec_next = dec_reg;
    if (read_clk_en) begin
      dec_next[4:0] = 5'h1F;
      case (mode)
        line_memory_pkg::timebase_correct_mode: begin
          dec_next[4] = ~(rn == line_memory_pkg::FULL_LAST);
        end
        line_memory_pkg::dual_line_delay_mode: begin
          dec_next[3] = ~((rn == line_memory_pkg::TAP_FIRST) & phase_reg);
          dec_next[2] = ~((rn == line_memory_pkg::TAP_SECOND) & phase_reg);
        end
        line_memory_pkg::delay_line_mode: begin
          dec_next[3] = ~((rn == line_memory_pkg::TAP_FIRST) |
                          (rn == line_memory_pkg::TAP_FIRST_LONG));
          dec_next[2] = ~((rn == line_memory_pkg::TAP_SECOND) |
                          (rn == line_memory_pkg::TAP_SECOND_LONG));
          dec_next[1] = ~(rn == line_memory_pkg::TAP_THIRD);
          dec_next[0] = ~(rn == line_memory_pkg::TAP_FOURTH);
        end
        default: begin
          dec_next[4:0] = 5'h1F;
        end
      endcase
    end
    if (write_clk_en) begin
      dec_next[5] = ~((mode == line_memory_pkg::timebase_correct_mode) &
                      (wn == line_memory_pkg::FULL_LAST));
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dec_reg <= line_memory_pkg::DECODE_IDLE;
    end else begin
      dec_reg <= dec_next;
    end
  end

  assign decode_out = line_memory_pkg::decode_type'(dec_reg);

endmodule // line_memory

// ### pkg/line_memory_pkg.sv
// constants, types and register map of the serial-access video line memory
// assumes one 40 MHz core clock; video clocks arrive as one-cycle enable pulses
package line_memory_pkg;

  // geometry
  localparam int unsigned ADDR_WIDTH = 11;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned DEPTH      = 2048;

  // inhibit limits and decode targets, as counter locations
  localparam logic [10:0] FULL_LAST      = 11'h7FF;  // 2047
  localparam logic [10:0] HALF_LAST      = 11'h3FF;  // 1023
  localparam logic [10:0] HALF_BASE      = 11'h400;  // 1024, second bank
  localparam logic [10:0] TAP_FIRST      = 11'd900;
  localparam logic [10:0] TAP_FIRST_LONG = 11'd1810;
  localparam logic [10:0] TAP_SECOND     = 11'd909;
  localparam logic [10:0] TAP_SECOND_LONG= 11'd1819;
  localparam logic [10:0] TAP_THIRD      = 11'd1134;
  localparam logic [10:0] TAP_FOURTH     = 11'd1125;

  // apb register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // control register reset: all mode bits high, delay select high
  localparam logic [31:0] CTRL_RESET = 32'h0000_000F;

  // control register fields, low four bits of the word
  typedef struct packed {
    logic delay_select;   // bit 3
    logic mode_select_c;  // bit 2
    logic mode_select_b;  // bit 1
    logic mode_select_a;  // bit 0
  } ctrl_type;

  // decoded mode, one-hot
  typedef enum logic [4:0] {
    compression_expansion_mode = 5'b00001,
    double_rate_mode           = 5'b00010,
    timebase_correct_mode      = 5'b00100,
    dual_line_delay_mode       = 5'b01000,
    delay_line_mode            = 5'b10000
  } mode_type;

  // active-low decode outputs travel together
  typedef struct packed {
    logic write_wrap_pulse_n;
    logic read_wrap_pulse_n;
    logic first_tap_pulse_n;
    logic second_tap_pulse_n;
    logic third_tap_pulse_n;
    logic fourth_tap_pulse_n;
  } decode_type;

  localparam logic [5:0] DECODE_IDLE = 6'h3F;

endpackage

// ### tb/line_memory_properties.sv
// pin-level assertions for the line memory, bound onto every line_memory
// assumes only the top-level ports are visible; one core clock domain
`timescale 1ns/1ps
module line_memory_properties (
  input wire logic                        core_clk,
  input wire logic                        resetn,
  input wire logic [7:0]                  paddr,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        read_clk_en,
  input wire logic                        write_clk_en,
  input wire logic                        output_gate_n,
  input wire logic [7:0]                  data_out,
  input wire logic                        data_out_oe,
  input wire line_memory_pkg::decode_type decode_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [4:0] rd_dec;  // decode bits stepped by the read clock
  assign rd_dec = decode_out[4:0];
  // a wrap location being left by a step of its own clock
  sequence wwrap_step; !decode_out.write_wrap_pulse_n && write_clk_en; endsequence
  sequence rwrap_step; !decode_out.read_wrap_pulse_n && read_clk_en; endsequence
  AST_OE: assert property (data_out_oe == !output_gate_n) else $error("oe wrong");
  AST_DOUT_HOLD: assert property (!$past(read_clk_en) && !$past(psel) |-> $stable(data_out))
    else $error("data moved without read clock");
  AST_WRITE_WRAP_PULSE_HOLD: assert property (!$past(write_clk_en) && !$past(psel)
    |-> $stable(decode_out.write_wrap_pulse_n)) else $error("write wrap moved");
  AST_READ_WRAP_PULSE_HOLD: assert property (!$past(read_clk_en) && !$past(psel) |-> $stable(rd_dec))
    else $error("read decode moved");
  AST_WWRAP_ONE: assert property (wwrap_step |=> decode_out.write_wrap_pulse_n)
    else $error("write wrap too long");
  AST_RWRAP_ONE: assert property (rwrap_step |=> decode_out.read_wrap_pulse_n)
    else $error("read wrap too long");
  AST_RESET_IDLE: assert property ($rose(resetn) |-> decode_out == 6'h3F && data_out == 8'h00)
    else $error("outputs not idle after reset");
  AST_PREADY: assert property (psel && penable |-> pready) else $error("no pready");
  AST_SLVERR: assert property (psel && penable |-> pslverr == !(paddr == 8'h00 || paddr == 8'h04))
    else $error("pslverr wrong");
endmodule // line_memory_properties

bind line_memory line_memory_properties u_props (.core_clk, .resetn, .paddr, .psel, .penable,
  .pready, .pslverr, .read_clk_en, .write_clk_en, .output_gate_n, .data_out, .data_out_oe,
  .decode_out);

// ### tb/video_source.sv
// video-side partner: read and write clock pulses, pointer clears, samples
// assumes the bench starts a burst with go and waits while busy is high
`timescale 1ns/1ps
module video_source (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        go,        // start a burst
  input wire logic        do_rd,     // pulse the read (common) clock
  input wire logic        do_wr,     // pulse the write clock
  input wire logic        do_clr,    // lead the burst with a clear cycle
  input wire logic [12:0] count,     // data pulses after the clear
  input wire logic [7:0]  pat,       // sample pattern
  output logic            busy,
  output logic            read_clk_en,
  output logic            write_clk_en,
  output logic            read_pointer_clear_n,
  output logic            write_pointer_clear_n,
  output logic [7:0]      data_in
);
  logic [12:0] left_reg;  // pulses still owed
  logic [10:0] idx_reg;   // samples since last clear
  logic        pend_reg;  // clear cycle owed
  logic        rd_reg;
  logic        wr_reg;
  logic        clr_cyc;
  assign clr_cyc = !read_pointer_clear_n || !write_pointer_clear_n;
  assign busy = pend_reg || (left_reg != 13'h0000) || read_clk_en || write_clk_en;
  // outside a sample pulse the input bus carries junk, the inverse of idx_reg[7:0] ^ pat
  assign data_in = ((read_clk_en || write_clk_en) && !clr_cyc) ? idx_reg[7:0] ^ pat
                                                              : ~(idx_reg[7:0] ^ pat);
  // pulses every other cycle; clears low only for their own cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      left_reg <= 13'h0000;
      idx_reg <= 11'h000;
      {pend_reg, rd_reg, wr_reg, read_clk_en, write_clk_en} <= 5'h00;
      {read_pointer_clear_n, write_pointer_clear_n} <= 2'b11;
    end else begin
      {read_clk_en, write_clk_en} <= 2'b00;
      {read_pointer_clear_n, write_pointer_clear_n} <= 2'b11;
      if (read_clk_en || write_clk_en) begin
        idx_reg <= clr_cyc ? 11'h000 : idx_reg + 11'h001;
      end
      if (go) begin
        {left_reg, pend_reg, rd_reg, wr_reg} <= {count, do_clr, do_rd, do_wr};
      end else if (!read_clk_en && !write_clk_en && (pend_reg || left_reg != 13'h0000)) begin
        {read_clk_en, write_clk_en} <= {rd_reg, wr_reg};
        if (pend_reg) begin
          // clear rides a pulse after high pre-reset cycles
          {read_pointer_clear_n, write_pointer_clear_n} <= {!rd_reg, !wr_reg};
          pend_reg <= 1'b0;
        end else begin
          left_reg <= left_reg - 13'h0001;
        end
      end
    end
  end
endmodule // video_source

// ### tb/video_line_memory_modes_tb.sv
// self-checking bench for the line memory: apb mode setup and video bursts
// assumes the video_source partner and the bound property checker
`timescale 1ns/1ps
module video_line_memory_modes_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, busy, data_out_oe;
  logic read_clk_en, write_clk_en, read_pointer_clear_n, write_pointer_clear_n;
  logic write_gate_n = 1'b0, output_gate_n = 1'b0;
  logic [7:0] data_in, data_out;
  line_memory_pkg::decode_type decode_out;
  logic go = 1'b0, do_rd = 1'b0, do_wr = 1'b0, do_clr = 1'b0;
  logic [12:0] count = 13'h0000;
  logic [7:0] pat = 8'h00;
  logic [7:0] exp_q[$];  // expected words for coming reads
  logic rd_seen = 1'b0;
  int err_total = 0, n_compared = 0, cyc = 0;

  always #12.5 core_clk = ~core_clk;

  line_memory u_dut (.core_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .read_clk_en, .write_clk_en, .read_pointer_clear_n,
    .write_pointer_clear_n, .write_gate_n, .write_timing_strobe(1'b1), .output_gate_n,
    .data_in, .data_out, .data_out_oe, .decode_out);
  video_source u_src (.core_clk, .resetn, .go, .do_rd, .do_wr, .do_clr, .count, .pat, .busy,
    .read_clk_en, .write_clk_en, .read_pointer_clear_n, .write_pointer_clear_n, .data_in);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // one burst of the partner, optionally led by a clear cycle
  task automatic run(input logic r, input logic w, input logic c, input int n,
                     input logic [7:0] p);
    @(posedge core_clk);
    {go, do_rd, do_wr, do_clr, count, pat} <= {1'b1, r, w, c, 13'(n), p};
    @(posedge core_clk);
    go <= 1'b0;
    // wait out the judgement of the last read step too, so that words queued
    // after this burst are never matched against its final output
    do @(negedge core_clk); while (busy || rd_seen);
  endtask

  // each read step is judged one cycle later against the queue
  always @(posedge core_clk) begin
    rd_seen <= read_clk_en && read_pointer_clear_n;
    if (rd_seen && exp_q.size() > 0) check(data_out, exp_q.pop_front());
  end

  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic t_apb;
    apb(1'b0, 8'h00, 32'h0000_0000);
    check(rdat, 32'h0000_000F);
    apb(1'b1, 8'h00, 32'h0000_0009);
    apb(1'b0, 8'h00, 32'h0000_0000);
    check(rdat, 32'h0000_0009);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check({rdat[30:0], rerr}, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_000F);
    $display("test apb done");
  endtask

  // full fill, inhibited overrun, clear restart, write gate, output gate
  task automatic t_fifo;
    run(1'b0, 1'b1, 1'b1, 2048, 8'h5A);
    run(1'b0, 1'b1, 1'b0, 10, 8'hA5);
    apb(1'b0, 8'h04, 32'h0000_0000);
    check(rdat[25], 1'b1);
    for (int k = 0; k < 10; k++) exp_q.push_back(8'(k) ^ 8'h5A);
    run(1'b1, 1'b0, 1'b1, 10, 8'h00);
    run(1'b0, 1'b1, 1'b1, 1, 8'hC3);
    apb(1'b0, 8'h04, 32'h0000_0000);
    check(rdat[25], 1'b0);
    write_gate_n <= 1'b1;
    run(1'b0, 1'b1, 1'b0, 1, 8'hC3);
    @(posedge core_clk);
    {write_gate_n, output_gate_n} <= 2'b01;
    run(1'b0, 1'b1, 1'b0, 1, 8'hC3);
    exp_q = '{8'hC3, 8'h5B, 8'hC1};
    run(1'b1, 1'b0, 1'b1, 3, 8'h00);
    check(data_out_oe, 1'b0);
    @(posedge core_clk);
    output_gate_n <= 1'b0;
    $display("test fifo done");
  endtask

  // wrap pulses at 2047 on both sides, free wrap, clear at 2047
  task automatic t_tbc;
    apb(1'b1, 8'h00, 32'h0000_0009);
    run(1'b1, 1'b1, 1'b1, 2046, 8'h00);
    check(decode_out[5:4], 2'b11);
    run(1'b1, 1'b1, 1'b0, 1, 8'h00);
    check(decode_out[5:4], 2'b00);
    run(1'b1, 1'b1, 1'b0, 1, 8'h00);
    check(decode_out[5:4], 2'b11);
    run(1'b1, 1'b1, 1'b0, 2047, 8'h00);
    check(decode_out[5:4], 2'b00);
    run(1'b0, 1'b1, 1'b1, 0, 8'h00);
    apb(1'b0, 8'h04, 32'h0000_0000);
    check(rdat[24:14], 11'h000);
    $display("test tbc done");
  endtask

  // double rate bank toggle and 1023 inhibit; dual delay first tap at 900
  task automatic t_modes;
    apb(1'b1, 8'h00, 32'h0000_0003);
    run(1'b0, 1'b1, 1'b1, 1030, 8'h00);
    apb(1'b0, 8'h04, 32'h0000_0000);
    check(rdat[26:25], 2'b11);
    apb(1'b1, 8'h00, 32'h0000_0002);
    run(1'b1, 1'b0, 1'b1, 1799, 8'h00);
    check(decode_out.first_tap_pulse_n, 1'b1);
    run(1'b1, 1'b0, 1'b0, 1, 8'h00);
    check(decode_out.first_tap_pulse_n, 1'b0);
    $display("test modes done");
  endtask

  // first tap at 900 and 1810, then a 2048-sample delay
  task automatic t_delay;
    apb(1'b1, 8'h00, 32'h0000_0008);
    run(1'b1, 1'b0, 1'b1, 899, 8'h33);
    check(decode_out.first_tap_pulse_n, 1'b1);
    run(1'b1, 1'b0, 1'b0, 1, 8'h33);
    check(decode_out.first_tap_pulse_n, 1'b0);
    run(1'b1, 1'b0, 1'b0, 910, 8'h33);
    check(decode_out.first_tap_pulse_n, 1'b0);
    run(1'b1, 1'b0, 1'b0, 1, 8'h33);
    check(decode_out.first_tap_pulse_n, 1'b1);
    run(1'b1, 1'b0, 1'b0, 237, 8'h33);
    for (int k = 0; k < 16; k++) exp_q.push_back(8'(k) ^ 8'h33);
    run(1'b1, 1'b0, 1'b0, 16, 8'hCC);
    check(exp_q.size(), 32'h0000_0000);
    $display("test delay done");
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_apb();
    t_fifo();
    t_tbc();
    t_modes();
    t_delay();
    tally_and_finish();
  end
endmodule // video_line_memory_modes_tb
